// ### core/psq_pkg.sv
package psq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 11;          // Counter spans bits 10..0
  localparam int PMEM_W = 15;        // Program word width
  localparam int STACK_DEPTH = 6;    // Return stack levels
  localparam int NUM_IRQ = 6;        // Vectored interrupt sources
  localparam int PAGE_W = 8;         // Page offset width
  localparam int TABLE_HIGH_LATCH_W = 7;         // High part of a table word

  // ----------------------------------------------------------------
  // Vectors and paging
  // ----------------------------------------------------------------
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  // External 0, external 1, timer 0, timer 1, serial, multi-function
  localparam logic [10:0] IRQ_VEC [0:5] = '{11'h004, 11'h008, 11'h00c,
                                            11'h010, 11'h014, 11'h018};
  localparam logic [2:0] LAST_PAGE_HI = 3'h7;   // Last page bits 10..8
  localparam logic [1:0] PHASE_LAST = 2'h3;     // Fourth phase of a cycle

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PCL = 8'h00;
  localparam logic [7:0] OFF_TBLP = 8'h04;
  localparam logic [7:0] OFF_TABLE_HIGH_LATCH = 8'h08;
  localparam logic [7:0] OFF_INT_EN = 8'h0c;
  localparam logic [7:0] OFF_INT_PEND = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] RST_TBLP = 8'h00;
  localparam logic [7:0] RST_INT_EN = 8'h00;
  localparam int INT_EN_GLOBAL = 7;  // Global enable bit position
  localparam int STAT_C = 0;         // Carry (inverted borrow)
  localparam int STAT_Z = 1;         // Zero
  localparam int STAT_OV = 2;        // Signed overflow

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    psq_op_next, psq_op_jump, psq_op_call, psq_op_ret,
    psq_op_return_from_interrupt, psq_op_skip, psq_op_tab_cur, psq_op_tab_last
  } psq_op_type;

  typedef enum logic [2:0] {
    psq_alu_add, psq_alu_sub, psq_alu_and, psq_alu_or,
    psq_alu_xor, psq_alu_pass
  } psq_alu_op_type;

  typedef struct packed {
    logic valid;              // Command presented for this cycle
    psq_op_type op;           // Flow operation
    logic [10:0] target;      // Jump or call address
  } psq_cmd_type;

  typedef struct packed {
    logic valid;              // Operation requested
    psq_alu_op_type op;       // Function
    logic [7:0] a;            // First operand
    logic [7:0] b;            // Second operand
  } psq_alu_req_type;

endpackage : psq_pkg

// ### core/psq_sequencer.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module psq_sequencer #(
  parameter int STACK_DEPTH = psq_pkg::STACK_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire psq_pkg::psq_cmd_type cmd,
  input wire psq_pkg::psq_alu_req_type alu_req,
  input wire logic [5:0] irq_req,
  output logic [10:0] pmem_addr,
  input wire logic [14:0] pmem_data,
  output logic [1:0] cycle_phases,
  output logic dummy_cycle,
  output logic [7:0] table_low,
  output logic table_low_valid,
  output logic [7:0] alu_result,
  output logic alu_result_valid,
  output logic irq_ack,
  output logic [10:0] irq_vector
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int SW = $clog2(STACK_DEPTH + 1);  // Level index width

  logic [10:0] pc;                  // Address being fetched, except during a table cycle
  logic table_cycle;                // Dummy cycle used by a table read
  logic [7:0] table_pointer;        // Table address bits 7..0
  logic [6:0] table_high_latch;     // High part of last table word
  logic [7:0] int_enable;           // Source enables and global enable
  logic [5:0] int_pend;             // Recorded requests
  logic pcl_wr_pend;                // Low byte write waiting
  logic [7:0] pcl_wr_data;          // Low byte written by software
  logic [2:0] status;               // ALU flags
  logic [10:0] stack_mem [STACK_DEPTH];  // Return addresses
  logic [SW-1:0] stack_ptr;         // Next slot to write
  logic [SW-1:0] stack_level_index; // Occupied levels

  // Finds the lowest pending source, which has the lowest vector
  function automatic logic [2:0] first_irq(input logic [5:0] req);
    first_irq = 3'h0;
    for (int i = psq_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        first_irq = 3'(i);
      end
    end
  endfunction : first_irq

  // ----------------------------------------------------------------
  // Sequencing decisions
  // ----------------------------------------------------------------
  wire boundary = (cycle_phases == psq_pkg::PHASE_LAST);
  wire live = boundary & ~dummy_cycle;
  wire cmd_go = live & cmd.valid;
  wire do_jump = cmd_go & (cmd.op == psq_pkg::psq_op_jump);
  wire do_call = cmd_go & (cmd.op == psq_pkg::psq_op_call);
  wire do_ret = cmd_go & (cmd.op == psq_pkg::psq_op_ret);
  wire do_return_from_interrupt = cmd_go & (cmd.op == psq_pkg::psq_op_return_from_interrupt);
  wire do_skip = cmd_go & (cmd.op == psq_pkg::psq_op_skip);
  wire do_tab_cur = cmd_go & (cmd.op == psq_pkg::psq_op_tab_cur);
  wire do_tab_last = cmd_go & (cmd.op == psq_pkg::psq_op_tab_last);
  wire do_tab = do_tab_cur | do_tab_last;
  wire branch_op = cmd_go & (cmd.op != psq_pkg::psq_op_next);
  wire do_pcl = live & pcl_wr_pend & ~branch_op;
  wire stack_full = (stack_level_index == SW'(STACK_DEPTH));
  wire [5:0] irq_live = int_pend & int_enable[5:0];
  wire irq_ok = int_enable[psq_pkg::INT_EN_GLOBAL] & (|irq_live)
                & ~stack_full;
  wire do_irq = live & ~branch_op & ~do_pcl & irq_ok;
  wire [2:0] irq_idx = first_irq(irq_live);
  wire [10:0] vec_sel = psq_pkg::IRQ_VEC[irq_idx];
  wire do_push = do_call | do_irq;
  wire do_pop = do_ret | do_return_from_interrupt;
  wire [SW-1:0] ptr_inc = (stack_ptr == SW'(STACK_DEPTH - 1)) ?
                          '0 : stack_ptr + SW'(1);
  wire [SW-1:0] ptr_dec = (stack_ptr == '0) ?
                          SW'(STACK_DEPTH - 1) : stack_ptr - SW'(1);
  wire [10:0] stack_top = stack_mem[ptr_dec];
  wire [2:0] tab_hi = do_tab_last ? psq_pkg::LAST_PAGE_HI : pc[10:8];
  wire [10:0] tab_addr = {tab_hi, table_pointer};
  // Target selection: full loads for branches, page jump for low byte
  wire [10:0] next_pc =
    (do_jump | do_call) ? cmd.target :
    do_pop ? stack_top :
    do_irq ? vec_sel :
    do_pcl ? {pc[10:8], pcl_wr_data} :
    do_tab ? pc :
    pc + 11'h1;
  wire [10:0] next_fetch = do_tab ? tab_addr : next_pc;
  wire next_dummy = branch_op | do_pcl | do_irq;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire hit_pcl = (paddr == psq_pkg::OFF_PCL);
  wire hit_tblp = (paddr == psq_pkg::OFF_TBLP);
  wire hit_table_high_latch = (paddr == psq_pkg::OFF_TABLE_HIGH_LATCH);
  wire hit_en = (paddr == psq_pkg::OFF_INT_EN);
  wire hit_pend = (paddr == psq_pkg::OFF_INT_PEND);
  wire hit_stat = (paddr == psq_pkg::OFF_STATUS);
  wire hit_any = hit_pcl | hit_tblp | hit_table_high_latch | hit_en | hit_pend
                 | hit_stat;
  // Read mux; table high is read-only, upper bits zero
  wire [31:0] next_rdata =
    hit_pcl ? {24'h000000, pc[7:0]} :
    hit_tblp ? {24'h000000, table_pointer} :
    hit_table_high_latch ? {25'h0000000, table_high_latch} :
    hit_en ? {24'h000000, int_enable} :
    hit_pend ? {26'h0000000, int_pend} :
    hit_stat ? {29'h00000000, status} :
    32'h00000000;
  wire wr_pcl = apb_wr & hit_pcl;
  wire wr_tblp = apb_wr & hit_tblp;
  wire wr_en = apb_wr & hit_en;
  wire [5:0] pend_clr = (apb_wr & hit_pend) ? pwdata[5:0] : 6'h00;
  // New requests win over clearing by software or acknowledge
  wire [5:0] ack_clr = do_irq ? (6'h01 << irq_idx) : 6'h00;
  wire [5:0] next_pend = (int_pend & ~pend_clr & ~ack_clr) | irq_req;

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  wire [8:0] sum = {1'b0, alu_req.a} + {1'b0, alu_req.b};
  wire [8:0] dif = {1'b0, alu_req.a} - {1'b0, alu_req.b};
  wire is_sub = (alu_req.op == psq_pkg::psq_alu_sub);
  wire is_add = (alu_req.op == psq_pkg::psq_alu_add);
  wire [7:0] next_alu =
    is_add ? sum[7:0] :
    is_sub ? dif[7:0] :
    (alu_req.op == psq_pkg::psq_alu_and) ? (alu_req.a & alu_req.b) :
    (alu_req.op == psq_pkg::psq_alu_or) ? (alu_req.a | alu_req.b) :
    (alu_req.op == psq_pkg::psq_alu_xor) ? (alu_req.a ^ alu_req.b) :
    alu_req.b;
  // Carry after add, inverted borrow after subtract
  wire next_c = is_add ? sum[8] : is_sub ? ~dif[8] :
                status[psq_pkg::STAT_C];
  wire next_ov = is_add ? ((alu_req.a[7] == alu_req.b[7]) &
                           (next_alu[7] != alu_req.a[7])) :
                 is_sub ? ((alu_req.a[7] != alu_req.b[7]) &
                           (next_alu[7] != alu_req.a[7])) :
                 status[psq_pkg::STAT_OV];
  wire [2:0] next_status = {next_ov, (next_alu == 8'h00), next_c};

  // ----------------------------------------------------------------
  // Phase divider and program counter
  // ----------------------------------------------------------------
  // Four phases, boundary at the end of the fourth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_phases <= 2'h0;
    end else begin
      cycle_phases <= cycle_phases + 2'h1;
    end
  end

  // Counter, fetch address and dummy marking at each boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= psq_pkg::RESET_VECTOR;
      pmem_addr <= psq_pkg::RESET_VECTOR;
      dummy_cycle <= 1'b0;
      table_cycle <= 1'b0;
    end else if (boundary) begin
      pc <= next_pc;
      pmem_addr <= next_fetch;
      dummy_cycle <= next_dummy;
      table_cycle <= do_tab;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Circular store: a push on a full stack overwrites the oldest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr <= '0;
      stack_level_index <= '0;
    end else if (do_push) begin
      stack_ptr <= ptr_inc;
      if (!stack_full) begin
        stack_level_index <= stack_level_index + SW'(1);
      end
    end else if (do_pop) begin
      stack_ptr <= ptr_dec;
      if (stack_level_index != '0) begin
        stack_level_index <= stack_level_index - SW'(1);
      end
    end
  end

  // Entry storage, no reset needed
  always_ff @(posedge pclk) begin
    if (do_push) begin
      stack_mem[stack_ptr] <= pc;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Requests recorded even while acknowledge is held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pend <= 6'h00;
      irq_ack <= 1'b0;
      irq_vector <= psq_pkg::RESET_VECTOR;
    end else begin
      int_pend <= next_pend;
      irq_ack <= do_irq;
      if (do_irq) begin
        irq_vector <= vec_sel;
      end
    end
  end

  // Enables: hardware masks on entry and unmasks on interrupt return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= psq_pkg::RST_INT_EN;
    end else if (do_irq) begin
      int_enable[psq_pkg::INT_EN_GLOBAL] <= 1'b0;  // Mask on entry
    end else if (do_return_from_interrupt) begin
      int_enable[psq_pkg::INT_EN_GLOBAL] <= 1'b1;
    end else if (wr_en) begin
      int_enable <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Low byte write waits for the next free boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcl_wr_pend <= 1'b0;
      pcl_wr_data <= 8'h00;
      table_pointer <= psq_pkg::RST_TBLP;
    end else begin
      if (wr_pcl) begin
        pcl_wr_pend <= 1'b1;
        pcl_wr_data <= pwdata[7:0];
      end else if (do_pcl) begin
        pcl_wr_pend <= 1'b0;
      end
      if (wr_tblp) begin
        table_pointer <= pwdata[7:0];
      end
    end
  end

  // Bus answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= next_rdata;
        pslverr <= ~hit_any;
      end
    end
  end

  // ----------------------------------------------------------------
  // Table capture and ALU result
  // ----------------------------------------------------------------
  // Word read during the table cycle splits into low byte and latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_low <= 8'h00;
      table_low_valid <= 1'b0;
      table_high_latch <= 7'h00;
    end else begin
      table_low_valid <= boundary & table_cycle;
      if (boundary && table_cycle) begin
        table_low <= pmem_data[7:0];
        table_high_latch <= pmem_data[14:8];
      end
    end
  end

  // Result and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_result <= 8'h00;
      alu_result_valid <= 1'b0;
      status <= 3'h0;
    end else begin
      alu_result_valid <= alu_req.valid;
      if (alu_req.valid) begin
        alu_result <= next_alu;
        status <= next_status;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pc_step: assert property (
    (live && !next_dummy && !do_tab) |=> pc == $past(pc) + 11'h1)
    else $error("Counter did not step by one");
  a_pcl_page: assert property (
    do_pcl |=> (pc[10:8] == $past(pc[10:8])) &&
               (pc[7:0] == $past(pcl_wr_data)) && dummy_cycle)
    else $error("Low byte jump left its page");
  a_skip_dummy: assert property (
    do_skip |=> dummy_cycle [*4] ##1 !dummy_cycle)
    else $error("Skip dummy cycle wrong length");
  a_call_push: assert property (
    do_call |=> stack_top == $past(pc) && pc == $past(cmd.target))
    else $error("Call did not push return address");
  a_ret_pop: assert property (
    (do_pop && stack_level_index != '0) |=>
      stack_level_index == $past(stack_level_index) - SW'(1))
    else $error("Return did not pop a level");
  a_full_inhibit: assert property (
    (stack_full && |irq_live && !(apb_wr && hit_pend)) |=>
      !irq_ack && ((int_pend & $past(irq_live)) == $past(irq_live)))
    else $error("Interrupt taken on full stack");
  a_irq_vector: assert property (
    do_irq |=> irq_ack && pc == $past(vec_sel) && pmem_addr == pc)
    else $error("Interrupt vector not loaded");
  a_full_call: assert property (
    (do_call && stack_full) |=> stack_level_index == SW'(STACK_DEPTH))
    else $error("Full stack call changed level");
  a_tab_last: assert property (
    do_tab_last |=> pmem_addr == {psq_pkg::LAST_PAGE_HI,
                                  $past(table_pointer)})
    else $error("Last page table address wrong");
  a_tab_two: assert property (
    do_tab |=> table_cycle [*4] ##1 table_low_valid)
    else $error("Table read not two cycles");

  c_call_full: cover property (do_call && stack_full);
  c_irq_taken: cover property (do_irq ##8 do_return_from_interrupt);
  c_tab_read: cover property (do_tab_cur ##5 table_low_valid);
  c_pcl_jump: cover property (wr_pcl ##[1:8] do_pcl);

endmodule : psq_sequencer

// ### testbench/psq_pmem_model.sv
`timescale 1ns/1ns
// --------------------
// Program memory model
// --------------------
module psq_pmem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [10:0] pmem_addr,
  output logic [14:0] pmem_data
);
  logic [10:0] addr_d1; // Address one cycle ago
  logic [10:0] addr_d2; // Address two cycles ago
  wire [14:0] word; // Fixed content of each word
  wire stale; // Address changed lately
  // 2K x 15 contents as a pattern of the address
  assign word = {pmem_addr[6:0] ^ 7'h2a, pmem_addr[7:0] ^ 8'h5c};
  assign stale = (pmem_addr != addr_d1) || (addr_d1 != addr_d2);
  // Registered read; slow mode shows toggling junk first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_d1 <= 11'h000;
      addr_d2 <= 11'h000;
      pmem_data <= 15'h0000;
    end else begin
      addr_d1 <= pmem_addr;
      addr_d2 <= addr_d1;
      if (slow && stale) begin
        pmem_data <= ~pmem_data; // Not ready yet
      end else begin
        pmem_data <= word; // Word at current address
      end
    end
  end
endmodule : psq_pmem_model

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ----------------
  // Signals
  // ----------------
  logic pclk = 1'h0; // System clock
  logic presetn = 1'h0; // Reset, active low
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'h0; // Memory answers late
  logic [5:0] irq_req = 6'h00; // Interrupt sources
  psq_pkg::psq_cmd_type cmd = '0; // Flow command
  psq_pkg::psq_alu_req_type alu_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, dummy_cycle, table_low_valid;
  logic alu_result_valid, irq_ack;
  logic [10:0] pmem_addr, irq_vector;
  logic [14:0] pmem_data;
  logic [1:0] cycle_phases;
  logic [7:0] table_low, alu_result;
  logic [31:0] rd; // Last read data
  logic er; // Last error flag
  logic [10:0] base, tba, r7, vx; // Addresses of interest
  logic [10:0] ra [0:5]; // Return addresses
  logic [14:0] w; // Expected table word
  int miscompares = 0;
  int checked = 0;
  int acks = 0;
  // Wait flags: ack, table, dummy, ready, free slot
  wire [4:0] flag = {cycle_phases === 2'h2 && dummy_cycle === 1'h0,
                     pready, dummy_cycle, table_low_valid, irq_ack};
  // ----------------
  // Instances
  // ----------------
  psq_sequencer dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmd, .alu_req, .irq_req, .pmem_addr, .pmem_data,
    .cycle_phases, .dummy_cycle, .table_low, .table_low_valid,
    .alu_result, .alu_result_valid, .irq_ack, .irq_vector
  );
  psq_pmem_model pmem (.pclk, .presetn, .slow, .pmem_addr, .pmem_data);
  // Clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Count interrupt entries
  always @(posedge pclk) begin
    if (irq_ack === 1'h1) acks++;
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  // Bounded wait for one flag
  task automatic await(input int sel);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge pclk);
      if (flag[sel] === 1'h1) break;
    end
    if (n == 300) begin
      miscompares++;
      summarize();
    end
  endtask : await
  // One APB transfer, zero or more wait states
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    await(3);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Issue a flow command at a free boundary
  task automatic op(input psq_pkg::psq_op_type o, input logic [10:0] t);
    await(4);
    base = pmem_addr;
    cmd <= '{1'h1, o, t};
    @(posedge pclk);
    cmd.valid <= 1'h0;
    @(posedge pclk);
  endtask : op
  function automatic logic [14:0] word(input logic [10:0] a);
    return {a[6:0] ^ 7'h2a, a[7:0] ^ 8'h5c};
  endfunction : word
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    // Phase count and first fetches after reset
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      chk(cycle_phases, i % 4);
      chk(pmem_addr, (i >= 4) ? 1 : 0);
    end
    apb(1'h0, 8'h40, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    $display("Test reset done");
    // ALU add then subtract, flags read back
    for (int i = 0; i < 2; i++) begin
      alu_req <= '{1'h1, i ? psq_pkg::psq_alu_sub : psq_pkg::psq_alu_add,
                   i ? 8'h80 : 8'hff, 8'h01};
      @(posedge pclk);
      alu_req.valid <= 1'h0;
      @(posedge pclk);
      chk({alu_result_valid, alu_result}, i ? 9'h17f : 9'h100);
      apb(1'h0, psq_pkg::OFF_STATUS, 32'h0);
      chk(rd, i ? 32'h5 : 32'h3);
    end
    alu_req <= '{1'h1, psq_pkg::psq_alu_xor, 8'h5a, 8'h5a};
    @(posedge pclk);
    alu_req.valid <= 1'h0;
    @(posedge pclk);
    chk({alu_result_valid, alu_result}, 9'h100);
    apb(1'h0, psq_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h7);
    $display("Test alu done");
    // Jump then sequential step; skip inserts dummy
    op(psq_pkg::psq_op_jump, 11'h3f0);
    chk({dummy_cycle, pmem_addr}, 12'hbf0);
    repeat (4) @(posedge pclk);
    chk({dummy_cycle, pmem_addr}, 12'h3f1);
    op(psq_pkg::psq_op_skip, 11'h000);
    chk({dummy_cycle, pmem_addr}, {1'h1, base + 11'h1});
    repeat (4) @(posedge pclk);
    chk({dummy_cycle, pmem_addr}, {1'h0, base + 11'h2});
    $display("Test flow done");
    // Table reads: current page prompt, last page slow
    apb(1'h1, psq_pkg::OFF_TBLP, 32'h06);
    apb(1'h0, psq_pkg::OFF_TBLP, 32'h0);
    chk(rd, 32'h06);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      op(k ? psq_pkg::psq_op_tab_last : psq_pkg::psq_op_tab_cur, 11'h0);
      tba = {k ? 3'h7 : base[10:8], 8'h06};
      w = word(tba);
      chk({dummy_cycle, pmem_addr}, {1'h1, tba});
      await(1);
      chk(table_low, w[7:0]);
      apb(1'h0, psq_pkg::OFF_TABLE_HIGH_LATCH, 32'h0);
      chk(rd, {25'h0, w[14:8]});
    end
    apb(1'h1, psq_pkg::OFF_TABLE_HIGH_LATCH, 32'h7f);
    apb(1'h0, psq_pkg::OFF_TABLE_HIGH_LATCH, 32'h0);
    chk(rd, {25'h0, w[14:8]});
    $display("Test table done");
    // Page jump by low counter byte write
    op(psq_pkg::psq_op_jump, 11'h5f0);
    apb(1'h1, psq_pkg::OFF_PCL, 32'h33);
    await(2);
    chk(pmem_addr, 11'h533);
    apb(1'h0, psq_pkg::OFF_PCL, 32'h0);
    chk(rd, 32'h33);
    $display("Test page done");
    // Fill stack, hold off interrupt, overflow call
    for (int i = 0; i < 6; i++) begin
      op(psq_pkg::psq_op_call, {i[2:0], 8'h40});
      ra[i] = base;
      chk(pmem_addr, {i[2:0], 8'h40});
    end
    apb(1'h1, psq_pkg::OFF_INT_EN, 32'h82);
    irq_req <= 6'h02;
    @(posedge pclk);
    irq_req <= 6'h00;
    repeat (40) @(posedge pclk);
    chk(acks, 0);
    apb(1'h0, psq_pkg::OFF_INT_PEND, 32'h0);
    chk(rd, 32'h2);
    op(psq_pkg::psq_op_call, 11'h7c0);
    r7 = base;
    chk(pmem_addr, 11'h7c0);
    op(psq_pkg::psq_op_ret, 11'h000);
    chk(pmem_addr, r7);
    await(0);
    op(psq_pkg::psq_op_return_from_interrupt, 11'h000);
    chk(irq_vector, 11'h008);
    for (int i = 5; i > 0; i--) begin
      op(psq_pkg::psq_op_ret, 11'h000);
      chk(pmem_addr, ra[i]);
    end
    $display("Test stack done");
    // Each source alone, then two at once
    apb(1'h1, psq_pkg::OFF_INT_EN, 32'hbf);
    for (int i = 0; i < 7; i++) begin
      irq_req <= (i < 6) ? 6'(1 << i) : 6'h21;
      @(posedge pclk);
      irq_req <= 6'h00;
      await(0);
      op(psq_pkg::psq_op_return_from_interrupt, 11'h000);
      vx = (i < 6) ? 11'(4 * i + 4) : 11'h004;
      chk(irq_vector, vx);
    end
    await(0);
    op(psq_pkg::psq_op_return_from_interrupt, 11'h000);
    chk(irq_vector, 11'h018);
    $display("Test vectors done");
    summarize();
  end
endmodule : testbench
